/* File: shared/supervisor_gpio_pkg.sv */
// Constants, field layouts, reset values and types for the GPIO block
// of the supervisor. Assumes a single 200 MHz clock domain.
//
// Contract
// - An alert-type pin latches asserted until ARA ack, history read or clear.
// - Release delay is ignored on any pin configured as an alert output.
// - Delay field decodes 0, 1.6, 6.4, 26, 51, 205, 410 ms and 1.64 s.
// - Every pin's release delay field resets to 101b, that is 205 ms.
// - Type 000b is an active-high input, 001b an active-low input.
// - Type 010b is open-drain active high, 011b open-drain active low.
// - Type 100b is an active-low open-drain latched alert output.
// - Type 101b is weak pull-up active high, 110b weak pull-up active low.
// - Type 111b is an active-low weak pull-up latched alert output.
// - Second and third pin type fields reset to 011b, open-drain active low.
// - First word bit 7 routes first pin to third, bit 6 to second.
// - Pair word bit 15 routes third pin to second, bit 14 to first.
// - Pair word bit 7 routes second pin to third, bit 6 to first.
// - Pair word: third delay 13:11, third type 10:8, second 5:3 and 2:0.
// - First word: delay 5:3, type 2:0, bits 15:8 reserved and ignored.
// - Per-channel bits map high/low faults to each pin; high- and low-to-first set.

package supervisor_gpio_pkg;

    // ----------------------------------------------------------------
    // Command codes and sizes
    // ----------------------------------------------------------------
    localparam logic [7:0] FIRST_PIN_CONFIG_CODE = 8'h02;
    localparam logic [7:0] SECOND_THIRD_PIN_CONFIG_CODE = 8'h03;
    localparam logic [7:0] CHANNEL_CONFIG_BASE_CODE = 8'h0A;
    localparam int CHANNELS = 6;
    localparam int PINS = 3;
    localparam int CNT_W = 29;
    localparam longint CLOCK_MHZ = 200;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FIRST_TO_THIRD_BIT = 7;
    localparam int FIRST_TO_SECOND_BIT = 6;
    localparam int THIRD_TO_SECOND_BIT = 15;
    localparam int THIRD_TO_FIRST_BIT = 14;
    localparam int SECOND_TO_THIRD_BIT = 7;
    localparam int SECOND_TO_FIRST_BIT = 6;
    localparam int LOW_DELAY_LSB = 3;
    localparam int LOW_TYPE_LSB = 0;
    localparam int HIGH_DELAY_LSB = 11;
    localparam int HIGH_TYPE_LSB = 8;
    localparam int HIGH_MAP_LSB = 3;
    localparam int LOW_MAP_LSB = 0;
    localparam logic [15:0] FIRST_USED_MASK = 16'h00FF;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] FIRST_CFG_RESET = 16'h0028;
    localparam logic [15:0] PAIR_CFG_RESET = 16'h2B2B;
    localparam logic [5:0] CHAN_MAP_RESET = 6'h09;
    localparam logic [2:0] DELAY_RESET = 3'h5;
    localparam logic [2:0] TYPE_RESET = 3'h3;

    // ----------------------------------------------------------------
    // Pin type codes
    // ----------------------------------------------------------------
    localparam logic [2:0] TYPE_IN_HIGH = 3'h0;
    localparam logic [2:0] TYPE_IN_LOW = 3'h1;
    localparam logic [2:0] TYPE_OD_HIGH = 3'h2;
    localparam logic [2:0] TYPE_OD_LOW = 3'h3;
    localparam logic [2:0] TYPE_OD_ALERT = 3'h4;
    localparam logic [2:0] TYPE_WEAK_HIGH = 3'h5;
    localparam logic [2:0] TYPE_WEAK_LOW = 3'h6;
    localparam logic [2:0] TYPE_WEAK_ALERT = 3'h7;
    localparam logic [2:0] DELAY_NONE = 3'h0;

    // ----------------------------------------------------------------
    // Release delay times and their cycle counts
    // ----------------------------------------------------------------
    localparam int unsigned RELEASE_US [8] =
        '{0, 1600, 6400, 26000, 51000, 205000, 410000, 1640000};

    function automatic logic [7:0][CNT_W-1:0] release_table();
        logic [7:0][CNT_W-1:0] t;
        for (int i = 0; i < 8; i++) begin
            t[i] = CNT_W'(longint'(RELEASE_US[i]) * CLOCK_MHZ);
        end
        return t;
    endfunction

    localparam logic [7:0][CNT_W-1:0] RELEASE_CYCLES = release_table();
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PIN_IDLE = 2'h0,
        PIN_ACTIVE = 2'h1,
        PIN_HOLD = 2'h3
    } pin_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic [15:0] first_cfg;
        logic [15:0] pair_cfg;
        logic [CHANNELS-1:0][5:0] chan_map;
        pin_state_t [PINS-1:0] st;
        logic [PINS-1:0][CNT_W-1:0] cnt;
        logic [PINS-1:0] alert;
        logic [PINS-1:0] pin_out;
        logic [PINS-1:0] pin_oe;
        logic [PINS-1:0] pin_weak;
        logic [15:0] rd_data;
        logic rd_valid;
    } state_t;

    // ----------------------------------------------------------------
    // Type decoding
    // ----------------------------------------------------------------
    function automatic logic type_is_input(input logic [2:0] t);
        return (t == TYPE_IN_HIGH) || (t == TYPE_IN_LOW);
    endfunction

    function automatic logic type_is_alert(input logic [2:0] t);
        return (t == TYPE_OD_ALERT) || (t == TYPE_WEAK_ALERT);
    endfunction

    function automatic logic type_is_weak(input logic [2:0] t);
        return (t == TYPE_WEAK_HIGH) || (t == TYPE_WEAK_LOW) ||
               (t == TYPE_WEAK_ALERT);
    endfunction

    function automatic logic type_is_high(input logic [2:0] t);
        return (t == TYPE_OD_HIGH) || (t == TYPE_WEAK_HIGH);
    endfunction

endpackage

/* File: logic/supervisor_gpio_config.sv */
// Three general-purpose pins: type, polarity, cross routing, fault
// mapping, release delays and the latched alert output.
// Assumes all inputs are synchronous to clock and that the command
// decoder delivers one-cycle command strobes.

`timescale 1ns/1ps

module supervisor_gpio_config
    import supervisor_gpio_pkg::*;
#(
    parameter logic [7:0][CNT_W-1:0] RELEASE_CYCLES_P = RELEASE_CYCLES
) (
    input wire logic clock, // 200 MHz clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire cmd_t cmd, // Command strobe, code and write data
    input wire logic alert_ack, // Alert response address acknowledged
    input wire logic history_read, // Fault history word was read
    input wire logic clear_history, // Clear-history command received
    input wire logic [CHANNELS-1:0] high_fault, // High comparator faults
    input wire logic [CHANNELS-1:0] low_fault, // Low comparator faults
    input wire logic [PINS-1:0] pin_in, // Pin levels seen at the pads
    output logic [PINS-1:0] pin_out, // Driven level, valid when enabled
    output logic [PINS-1:0] pin_oe, // High while the pad sinks low
    output logic [PINS-1:0] pin_weak, // Weak pull-up stage enabled
    output logic [15:0] rd_data, // Read answer
    output logic rd_valid // Read answer strobe
);

    state_t s_reg;
    state_t s_next;
    logic [PINS-1:0][2:0] ptype;
    logic [PINS-1:0][2:0] pdly;
    logic [PINS-1:0] in_asserted;
    logic [PINS-1:0] src;
    logic [PINS-1:0][PINS-1:0] route;
    logic clear_event;

    // ----------------------------------------------------------------
    // Field extraction and source combining
    // ----------------------------------------------------------------
    // first word and pair word layout
    assign ptype[0] = s_reg.first_cfg[LOW_TYPE_LSB +: 3];
    assign pdly[0] = s_reg.first_cfg[LOW_DELAY_LSB +: 3];
    assign ptype[1] = s_reg.pair_cfg[LOW_TYPE_LSB +: 3];
    assign pdly[1] = s_reg.pair_cfg[LOW_DELAY_LSB +: 3];
    assign ptype[2] = s_reg.pair_cfg[HIGH_TYPE_LSB +: 3];
    assign pdly[2] = s_reg.pair_cfg[HIGH_DELAY_LSB +: 3];

    assign route[0][0] = 1'b0;
    assign route[0][1] = s_reg.first_cfg[FIRST_TO_SECOND_BIT];
    assign route[0][2] = s_reg.first_cfg[FIRST_TO_THIRD_BIT];
    assign route[1][0] = s_reg.pair_cfg[SECOND_TO_FIRST_BIT];
    assign route[1][1] = 1'b0;
    assign route[1][2] = s_reg.pair_cfg[SECOND_TO_THIRD_BIT];
    assign route[2][0] = s_reg.pair_cfg[THIRD_TO_FIRST_BIT];
    assign route[2][1] = s_reg.pair_cfg[THIRD_TO_SECOND_BIT];
    assign route[2][2] = 1'b0;

    assign clear_event = alert_ack | history_read | clear_history;

    generate
        for (genvar p = 0; p < PINS; p++) begin : g_src
            assign in_asserted[p] = type_is_input(ptype[p]) &&
                (pin_in[p] ^ (ptype[p] == TYPE_IN_LOW));

            always_comb begin
                src[p] = 1'b0;
                for (int c = 0; c < CHANNELS; c++) begin
                    src[p] = src[p] |
                        (high_fault[c] & s_reg.chan_map[c][HIGH_MAP_LSB + p]) |
                        (low_fault[c] & s_reg.chan_map[c][LOW_MAP_LSB + p]);
                end
                // Only pins that are inputs feed other pins
                for (int q = 0; q < PINS; q++) begin
                    src[p] = src[p] | (in_asserted[q] & route[q][p]);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic active;
        logic level;
        active = 1'b0;
        level = 1'b0;
        s_next = s_reg;
        s_next.rd_valid = 1'b0;

        if (cmd.valid && cmd.write) begin
            if (cmd.code == FIRST_PIN_CONFIG_CODE) begin
                s_next.first_cfg = cmd.wdata & FIRST_USED_MASK;
            end
            if (cmd.code == SECOND_THIRD_PIN_CONFIG_CODE) begin
                s_next.pair_cfg = cmd.wdata;
            end
            for (int c = 0; c < CHANNELS; c++) begin
                if (cmd.code == CHANNEL_CONFIG_BASE_CODE + 8'(c)) begin
                    s_next.chan_map[c] = cmd.wdata[5:0];
                end
            end
        end

        if (cmd.valid && !cmd.write) begin
            s_next.rd_valid = 1'b1;
            s_next.rd_data = 16'h0000;
            if (cmd.code == FIRST_PIN_CONFIG_CODE) begin
                s_next.rd_data = s_reg.first_cfg;
            end
            if (cmd.code == SECOND_THIRD_PIN_CONFIG_CODE) begin
                s_next.rd_data = s_reg.pair_cfg;
            end
            for (int c = 0; c < CHANNELS; c++) begin
                if (cmd.code == CHANNEL_CONFIG_BASE_CODE + 8'(c)) begin
                    s_next.rd_data = {10'h000, s_reg.chan_map[c]};
                end
            end
        end

        for (int p = 0; p < PINS; p++) begin
            if (type_is_alert(ptype[p])) begin
                s_next.st[p] = PIN_IDLE;
                s_next.cnt[p] = CNT_ZERO;
                // latch, a new fault wins over a clear
                s_next.alert[p] = src[p] | (s_reg.alert[p] & ~clear_event);
            end else if (type_is_input(ptype[p])) begin
                s_next.st[p] = PIN_IDLE;
                s_next.cnt[p] = CNT_ZERO;
                s_next.alert[p] = 1'b0;
            end else begin
                s_next.alert[p] = 1'b0;
                // assert on source, stretch the release
                case (s_reg.st[p])
                    PIN_IDLE: begin
                        if (src[p]) begin
                            s_next.st[p] = PIN_ACTIVE;
                        end
                    end
                    PIN_ACTIVE: begin
                        if (!src[p]) begin
                            if (pdly[p] == DELAY_NONE) begin
                                s_next.st[p] = PIN_IDLE;
                            end else begin
                                s_next.st[p] = PIN_HOLD;
                                s_next.cnt[p] = RELEASE_CYCLES_P[pdly[p]] -
                                    CNT_ONE;
                            end
                        end
                    end
                    PIN_HOLD: begin
                        if (src[p]) begin
                            s_next.st[p] = PIN_ACTIVE;
                        end else if (s_reg.cnt[p] == CNT_ZERO) begin
                            s_next.st[p] = PIN_IDLE;
                        end else begin
                            s_next.cnt[p] = s_reg.cnt[p] - CNT_ONE;
                        end
                    end
                    default: begin
                        s_next.st[p] = PIN_IDLE;
                    end
                endcase
            end

            active = type_is_alert(ptype[p]) ? s_next.alert[p] :
                (s_next.st[p] != PIN_IDLE);
            level = active ^ ~type_is_high(ptype[p]);
            if (type_is_input(ptype[p])) begin
                s_next.pin_out[p] = 1'b0;
                s_next.pin_oe[p] = 1'b0;
                s_next.pin_weak[p] = 1'b0;
            end else begin
                // output stage, low is sunk strongly
                s_next.pin_out[p] = level;
                s_next.pin_oe[p] = ~level;
                s_next.pin_weak[p] = level & type_is_weak(ptype[p]);
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.first_cfg <= FIRST_CFG_RESET;
            s_reg.pair_cfg <= PAIR_CFG_RESET;
            // high and low faults to first pin by default
            s_reg.chan_map <= {CHANNELS{CHAN_MAP_RESET}};
            // Idle output pins release the pad
            s_reg.pin_out <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pin_out = s_reg.pin_out;
    assign pin_oe = s_reg.pin_oe;
    assign pin_weak = s_reg.pin_weak;
    assign rd_data = s_reg.rd_data;
    assign rd_valid = s_reg.rd_valid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic pair_written;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pair_written <= 1'b0;
        end else if (cmd.valid && cmd.write &&
                     cmd.code == SECOND_THIRD_PIN_CONFIG_CODE) begin
            pair_written <= 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_pair_defaults:
    assert property (!pair_written |->
        s_reg.pair_cfg[HIGH_DELAY_LSB +: 3] == DELAY_RESET &&
        s_reg.pair_cfg[LOW_TYPE_LSB +: 3] == TYPE_RESET)
    else $error("pair word lost its defaults");

    a_first_route:
    assert property (in_asserted[0] && route[0][2] |-> src[2])
    else $error("first pin not routed to third");

    generate
        for (genvar p = 0; p < PINS; p++) begin : g_chk
            a_alert_hold:
            assert property (s_reg.alert[p] && !clear_event &&
                type_is_alert(ptype[p]) |=> s_reg.alert[p])
            else $error("alert released without a clearing event");

            a_alert_clear:
            assert property (s_reg.alert[p] && clear_event && !src[p] &&
                type_is_alert(ptype[p]) |=> !s_reg.alert[p])
            else $error("alert not cleared");

            a_alert_nodelay:
            assert property (type_is_alert(ptype[p]) |=>
                s_reg.st[p] == PIN_IDLE)
            else $error("release delay used on an alert pin");

            a_alert_drive:
            assert property (type_is_alert(ptype[p]) |=>
                pin_oe[p] == s_reg.alert[p] && !(pin_oe[p] && pin_weak[p]))
            else $error("alert pin not active low");

            a_delay_load:
            assert property (s_reg.st[p] == PIN_ACTIVE && !src[p] &&
                !type_is_input(ptype[p]) && !type_is_alert(ptype[p]) &&
                pdly[p] != DELAY_NONE |=> s_reg.st[p] == PIN_HOLD &&
                s_reg.cnt[p] == RELEASE_CYCLES_P[$past(pdly[p])] - CNT_ONE)
            else $error("release count loaded wrongly");

            a_delay_none:
            assert property (s_reg.st[p] == PIN_ACTIVE && !src[p] &&
                !type_is_input(ptype[p]) && !type_is_alert(ptype[p]) &&
                pdly[p] == DELAY_NONE |=> s_reg.st[p] == PIN_IDLE)
            else $error("zero delay did not release at once");

            a_hold_retrigger:
            assert property (s_reg.st[p] == PIN_HOLD && src[p] &&
                !type_is_input(ptype[p]) && !type_is_alert(ptype[p])
                |=> s_reg.st[p] == PIN_ACTIVE)
            else $error("fault during release not reasserted");

            a_input_quiet:
            assert property (type_is_input(ptype[p]) |=>
                !pin_oe[p] && !pin_weak[p] && s_reg.st[p] == PIN_IDLE)
            else $error("input pin driven");

            a_od_level:
            assert property (ptype[p] == TYPE_OD_LOW |=>
                pin_oe[p] == (s_reg.st[p] != PIN_IDLE) && !pin_weak[p])
            else $error("open-drain active low level wrong");

            a_weak_stage:
            assert property (ptype[p] == TYPE_WEAK_HIGH |=>
                pin_weak[p] == (s_reg.st[p] != PIN_IDLE) &&
                pin_oe[p] == !pin_weak[p])
            else $error("weak pull-up stage wrong");
        end
    endgenerate

endmodule // supervisor_gpio_config

/* File: sim/smbus_host_model.sv */
// Host model that services a latched alert on request of the bench.
// Assumes the bench raises req for one cycle, changed on the falling edge.

`timescale 1ns/1ps

module smbus_host_model (
    input wire logic clock, // Bench clock
    input wire logic sys_rst, // Reset, active high
    input wire logic req, // Service request from the bench
    input wire logic [1:0] kind, // 0 ack, 1 history read, 2 clear
    input wire logic slow, // Answer only after some idle cycles
    output logic alert_ack, // Alert response address acknowledged
    output logic history_read, // History word read
    output logic clear_history // Clear-history command
);
    int wait_left;
    logic pend;
    logic [1:0] k;

    // --------------------------------------------------------------
    // Service sequencer
    // --------------------------------------------------------------
    always @(negedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            {alert_ack, history_read, clear_history, pend} <= 4'h0;
            wait_left <= 0;
            k <= 2'h0;
        end else begin
            {alert_ack, history_read, clear_history} <= 3'h0;
            if (req) begin
                pend <= 1'b1;
                k <= kind;
                wait_left <= slow ? 6 : 0;
            end else if (pend && wait_left > 0) begin
                wait_left <= wait_left - 1;
            end else if (pend) begin
                pend <= 1'b0;
                alert_ack <= (k == 2'h0);
                history_read <= (k == 2'h1);
                clear_history <= (k == 2'h2);
            end
        end
    end
endmodule // smbus_host_model

/* File: sim/tb_supervisor_gpio_config.sv */
// Self-checking bench for the GPIO configuration block.
// Assumes short release counts and stimulus on the falling clock edge.

`timescale 1ns/1ps

module tb_supervisor_gpio_config
    import supervisor_gpio_pkg::*;
;
    // Short counts keep the run brief; index 0 must stay zero
    localparam logic [7:0][CNT_W-1:0] RC = {29'h9, 29'h8, 29'h7, 29'h6,
        29'h5, 29'h4, 29'h3, 29'h0};
    logic clock = 1'b0;
    logic sys_rst, alert_ack, history_read, clear_history, rd_valid;
    logic req, slow;
    logic [1:0] kind;
    cmd_t cmd;
    logic [5:0] high_fault, low_fault;
    logic [2:0] pin_in, pin_out, pin_oe, pin_weak;
    logic [15:0] rd_data, v;
    logic [15:0] fw [6] = '{16'h0080, 16'h0040, 16'h0003, 16'h0003,
        16'h0003, 16'h0003};
    logic [15:0] pw [6] = '{16'h0303, 16'h0303, 16'h8003, 16'h4003,
        16'h0380, 16'h0340};
    int src [6] = '{0, 0, 2, 2, 1, 1};
    int dst [6] = '{2, 1, 1, 0, 2, 0};
    logic [2:0] tl [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    int n;

    always #2.5 clock = ~clock;

    supervisor_gpio_config #(.RELEASE_CYCLES_P(RC)) dut (.clock(clock),
        .sys_rst(sys_rst), .cmd(cmd), .alert_ack(alert_ack),
        .history_read(history_read), .clear_history(clear_history),
        .high_fault(high_fault), .low_fault(low_fault), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_weak(pin_weak),
        .rd_data(rd_data), .rd_valid(rd_valid));

    smbus_host_model host (.clock(clock), .sys_rst(sys_rst), .req(req),
        .kind(kind), .slow(slow), .alert_ack(alert_ack),
        .history_read(history_read), .clear_history(clear_history));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
            fails++;
        end
    endtask

    task wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clock);
        cmd = '{1'b1, 1'b1, c, d};
        @(negedge clock);
        cmd.valid = 1'b0;
        repeat (2) @(negedge clock);
    endtask

    task rd(input logic [7:0] c, output logic [15:0] d);
        @(negedge clock);
        cmd = '{1'b1, 1'b0, c, 16'h0000};
        @(negedge clock);
        // The answer strobe stands for one cycle only
        d = rd_data;
        chk({15'h0000, rd_valid}, 16'h0001);
        cmd.valid = 1'b0;
    endtask

    // Expected {oe, weak} of a pin for its type and asserted state
    function automatic logic [15:0] drv(logic [2:0] t, logic a);
        case (t)
            3'h2: return a ? 16'h0000 : 16'h0002;
            3'h3, 3'h4: return a ? 16'h0002 : 16'h0000;
            3'h5: return a ? 16'h0001 : 16'h0002;
            3'h6, 3'h7: return a ? 16'h0002 : 16'h0001;
            default: return 16'h0000;
        endcase
    endfunction

    task clr(input logic [1:0] k, input logic s);
        @(negedge clock);
        req <= 1'b1;
        kind <= k;
        slow <= s;
        @(negedge clock);
        req <= 1'b0;
        for (int j = 0; j < 20 && pin_oe[1]; j++) @(negedge clock);
        @(negedge clock);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial begin
        cmd = '0;
        {high_fault, low_fault, pin_in} = '0;
        {req, slow, kind} = '0;
        sys_rst = 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        chk({7'h00, pin_out, pin_oe, pin_weak}, 16'h0180);
        rd(8'h02, v); chk(v, 16'h0028);
        rd(8'h03, v); chk(v, 16'h2B2B);
        rd(8'h0A, v); chk(v, 16'h0009);
        rd(8'h20, v); chk(v, 16'h0000);
        wr(8'h02, 16'hFF28);
        rd(8'h02, v); chk(v, 16'h0028);
        // Default channel maps steer both comparators to the first pin
        wr(8'h02, 16'h0003);
        high_fault[5] = 1'b1;
        repeat (2) @(negedge clock);
        chk({13'h0000, pin_oe}, 16'h0001);
        low_fault[2] = 1'b1;
        high_fault[5] = 1'b0;
        repeat (2) @(negedge clock);
        chk({13'h0000, pin_oe}, 16'h0001);
        low_fault[2] = 1'b0;
        repeat (2) @(negedge clock);
        chk({13'h0000, pin_oe}, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            wr(8'h02, fw[i]);
            wr(8'h03, pw[i]);
            chk({13'h0000, pin_oe}, 16'h0000);
            pin_in[src[i]] = 1'b1;
            repeat (2) @(negedge clock);
            chk({13'h0000, pin_oe}, 16'(1 << dst[i]));
            pin_in = '0;
            repeat (2) @(negedge clock);
        end
        wr(8'h02, 16'h0040);
        for (int d = 0; d < 8; d++) begin
            wr(8'h03, 16'h0303 | 16'(d << 3));
            pin_in[0] = 1'b1;
            repeat (2) @(negedge clock);
            pin_in[0] = 1'b0;
            n = 0;
            do begin
                @(negedge clock);
                n++;
            end while (pin_oe[1] && n < 40);
            chk(16'(n), 16'(RC[d] + 1));
        end
        for (int i = 0; i < 12; i++) begin
            wr(8'h03, 16'h0300 | 16'(tl[i / 2]));
            pin_in[0] = i[0];
            repeat (2) @(negedge clock);
            v = drv(tl[i / 2], i[0]);
            chk({14'h0000, pin_oe[1], pin_weak[1]}, v);
        end
        // Active-low input on the first pin, routed to the second
        wr(8'h02, 16'h0041);
        wr(8'h03, 16'h0303);
        pin_in[0] = 1'b0;
        repeat (2) @(negedge clock);
        chk({13'h0000, pin_oe}, 16'h0002);
        chk({13'h0000, pin_out}, 16'h0004);
        pin_in[0] = 1'b1;
        repeat (2) @(negedge clock);
        chk({13'h0000, pin_oe}, 16'h0000);
        pin_in = '0;
        wr(8'h02, 16'h0000);
        wr(8'h0A, 16'h0010);
        // only the second pin is ever an alert output
        for (int i = 0; i < 6; i++) begin
            wr(8'h03, 16'h0328 | (i < 3 ? 16'h0004 : 16'h0007));
            high_fault[0] = 1'b1;
            @(negedge clock);
            high_fault[0] = 1'b0;
            repeat (20) @(negedge clock);
            v = drv(i < 3 ? 3'h4 : 3'h7, 1'b1);
            chk({14'h0000, pin_oe[1], pin_weak[1]}, v);
            clr(2'(i % 3), i[0]);
            v = drv(i < 3 ? 3'h4 : 3'h7, 1'b0);
            chk({14'h0000, pin_oe[1], pin_weak[1]}, v);
        end
        // A clear while the fault stands must not release the alert
        high_fault[0] = 1'b1;
        clr(2'h2, 1'b0);
        chk({13'h0000, pin_oe}, 16'h0002);
        high_fault[0] = 1'b0;
        clr(2'h0, 1'b1);
        chk({13'h0000, pin_oe}, 16'h0000);
        end_of_test();
    end
endmodule // tb_supervisor_gpio_config
